// file: verilog/aoc_channel.v
`timescale 1ns/1ps
`include "aoc_map.vh"
module aoc_channel #(
  parameter [31:0] WD_CYC = `AOC_WD_CYC,
  parameter [31:0] SLOW_CYC = `AOC_SLOW_CYC,
  parameter [31:0] FAST_CYC = `AOC_FAST_CYC
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire frame_in,
  input wire [7:0] ctrl_in,
  input wire [15:0] data_in,
  output reg [7:0] status_out,
  output reg [15:0] rdata_out,
  output reg [15:0] dac_out,
  output reg run_out,
  output reg nv_commit_out
);
  reg rst_s1_r, rst_s2_r;
  reg frm_s1_r, frm_s2_r, frm_d_r;
  reg [7:0] ctl_s1_r, ctl_s2_r;
  reg [15:0] dat_s1_r, dat_s2_r;
  reg [15:0] align_r, hwofs_r, hwgain_r, mkofs_r, mkfac_r, code_r;
  reg [15:0] feat_r, usofs_r, usfac_r, usfb_r, x_r;
  reg [31:0] wd_cnt_r, step_cnt_r;
  reg wd_ovf_r;
  reg [15:0] rd_nxt;
  wire rst_n;
  wire frame_evt;
  wire unlocked;
  wire reg_mode, reg_wr;
  wire [5:0] addr;
  wire trim;
  wire [31:0] step_lim;
  wire step_due;
  wire [15:0] y0, y1m, y2u, y1, y2, fb_val, dac_nxt;
  wire signed [32:0] gain_prod;

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // coupler bus comes from another domain: two stages before use
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frm_s1_r <= 1'b0;
      frm_s2_r <= 1'b0;
      frm_d_r <= 1'b0;
      ctl_s1_r <= 8'h00;
      ctl_s2_r <= 8'h00;
      dat_s1_r <= 16'h0000;
      dat_s2_r <= 16'h0000;
    end
    else
    begin
      frm_s1_r <= frame_in;
      frm_s2_r <= frm_s1_r;
      frm_d_r <= frm_s2_r;
      ctl_s1_r <= ctrl_in;
      ctl_s2_r <= ctl_s1_r;
      dat_s1_r <= data_in;
      dat_s2_r <= dat_s1_r;
    end
  end
  // coupler holds ctrl and data stable around the frame strobe
  assign frame_evt = frm_s2_r & ~frm_d_r;

  assign unlocked = (code_r == `AOC_UNLOCK);
  assign reg_mode = ctl_s2_r[`AOC_C_REG];
  assign reg_wr = frame_evt & reg_mode & ctl_s2_r[`AOC_C_WR];
  assign addr = ctl_s2_r[5:0];
  assign trim = ~ctl_s2_r[`AOC_C_REG] & ctl_s2_r[`AOC_C_WR] & unlocked;
  assign step_lim = ctl_s2_r[`AOC_C_FAST] ? FAST_CYC : SLOW_CYC;
  assign step_due = trim & (step_cnt_r >= step_lim - 32'd1);

  // parameter storage; these registers mirror the nonvolatile copy
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      align_r <= `AOC_RST_ZERO;
      hwofs_r <= `AOC_RST_ZERO;
      hwgain_r <= `AOC_RST_GAIN;
      mkofs_r <= `AOC_RST_ZERO;
      mkfac_r <= `AOC_RST_FAC;
      code_r <= `AOC_RST_ZERO;
      feat_r <= `AOC_RST_FEAT;
      usofs_r <= `AOC_RST_ZERO;
      usfac_r <= `AOC_RST_FAC;
      usfb_r <= `AOC_RST_ZERO;
      x_r <= `AOC_RST_ZERO;
      step_cnt_r <= 32'd0;
      nv_commit_out <= 1'b0;
    end
    else
    begin
      nv_commit_out <= 1'b0;
      if (frame_evt && !reg_mode)
        x_r <= dat_s2_r;
      if (reg_wr)
      begin
        case (addr)
          `AOC_A_ALIGN: align_r <= dat_s2_r;
          `AOC_A_CODE:
          begin
            code_r <= dat_s2_r;
            // leaving unlock stores parameters, including trims
            if (unlocked && dat_s2_r != `AOC_UNLOCK)
              nv_commit_out <= 1'b1;
          end
          // user area also sits behind the code word
          `AOC_A_FEAT: if (unlocked) feat_r <= dat_s2_r;
          `AOC_A_USOFS: if (unlocked) usofs_r <= dat_s2_r;
          `AOC_A_USFAC: if (unlocked) usfac_r <= dat_s2_r;
          `AOC_A_USFB: if (unlocked) usfb_r <= dat_s2_r;
          `AOC_A_HWOFS: if (unlocked) hwofs_r <= dat_s2_r;
          `AOC_A_HWGAIN: if (unlocked) hwgain_r <= dat_s2_r;
          `AOC_A_MKOFS: if (unlocked) mkofs_r <= dat_s2_r;
          `AOC_A_MKFAC: if (unlocked) mkfac_r <= dat_s2_r;
          default: ;
        endcase
      end
      // trim stepping on hardware gain/offset, clamped at the ends
      if (!trim)
        step_cnt_r <= 32'd0;
      else if (step_due)
      begin
        step_cnt_r <= 32'd0;
        if (ctl_s2_r[`AOC_C_GAIN])
        begin
          if (ctl_s2_r[`AOC_C_UP] && hwgain_r != 16'hffff)
            hwgain_r <= hwgain_r + 16'h0001;
          else if (ctl_s2_r[`AOC_C_DOWN] && hwgain_r != 16'h0000)
            hwgain_r <= hwgain_r - 16'h0001;
        end
        else if (ctl_s2_r[`AOC_C_OFS])
        begin
          if (ctl_s2_r[`AOC_C_UP] && hwofs_r != 16'h7fff)
            hwofs_r <= hwofs_r + 16'h0001;
          else if (ctl_s2_r[`AOC_C_DOWN] && hwofs_r != 16'h8000)
            hwofs_r <= hwofs_r - 16'h0001;
        end
      end
      else
        step_cnt_r <= step_cnt_r + 32'd1;
    end
  end

  // watchdog: only process frames restart it; overflow latches until data arrives
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_cnt_r <= 32'd0;
      wd_ovf_r <= 1'b1;
    end
    else if (frame_evt && !reg_mode)
    begin
      wd_cnt_r <= 32'd0;
      wd_ovf_r <= 1'b0;
    end
    else if (!feat_r[`AOC_F_WDOFF] && !wd_ovf_r)
    begin
      if (wd_cnt_r >= WD_CYC - 32'd1)
        wd_ovf_r <= 1'b1;
      else
        wd_cnt_r <= wd_cnt_r + 32'd1;
    end
  end

  // hardware trim stage is the unity path before the lines
  // full-width product; a concatenation would cut it to 17 bits
  assign gain_prod = $signed(x_r) * $signed({1'b0, hwgain_r});
  aoc_line u_hw (
    .x_in(gain_prod[31:16]),
    .factor_in(16'h0100),
    .signed_factor_in(1'b0),
    .offset_in(hwofs_r),
    .y_out(y0)
  );
  aoc_line u_mk (
    .x_in(y0),
    .factor_in(mkfac_r),
    .signed_factor_in(1'b0),
    .offset_in(mkofs_r),
    .y_out(y1m)
  );
  assign y1 = feat_r[`AOC_F_MAKER] ? y1m : y0;
  aoc_line u_us (
    .x_in(y1),
    .factor_in(usfac_r),
    .signed_factor_in(1'b1),
    .offset_in(usofs_r),
    .y_out(y2u)
  );
  assign y2 = feat_r[`AOC_F_USER] ? y2u : y1;
  // maker fallback value is not stored separately; it is zero volts
  assign fb_val = feat_r[`AOC_F_FBSEL] ? usfb_r : `AOC_RST_ZERO;
  assign dac_nxt = wd_ovf_r ? fb_val : y2;

  always @*
  begin
    rd_nxt = 16'h0000;
    case (addr)
      `AOC_A_RAW: rd_nxt = dac_out;
      `AOC_A_TYPE: rd_nxt = `AOC_TYPE_ID;
      `AOC_A_FW: rd_nxt = `AOC_FW_VER;
      `AOC_A_SRLEN: rd_nxt = `AOC_SRLEN_VAL;
      `AOC_A_CHCNT: rd_nxt = `AOC_CHCNT_VAL;
      `AOC_A_MINLEN: rd_nxt = `AOC_MINLEN_VAL;
      `AOC_A_DTYPE: rd_nxt = `AOC_DTYPE_VAL;
      `AOC_A_ALIGN: rd_nxt = align_r;
      `AOC_A_HWOFS: rd_nxt = hwofs_r;
      `AOC_A_HWGAIN: rd_nxt = hwgain_r;
      `AOC_A_MKOFS: rd_nxt = mkofs_r;
      `AOC_A_MKFAC: rd_nxt = mkfac_r;
      `AOC_A_CODE: rd_nxt = unlocked ? `AOC_UNLOCK : 16'h0000;
      `AOC_A_FEAT: rd_nxt = feat_r;
      `AOC_A_USOFS: rd_nxt = usofs_r;
      `AOC_A_USFAC: rd_nxt = usfac_r;
      `AOC_A_USFB: rd_nxt = usfb_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_out <= 8'h00;
      rdata_out <= 16'h0000;
      dac_out <= 16'h0000;
      run_out <= 1'b0;
    end
    else
    begin
      dac_out <= dac_nxt;
      run_out <= ~wd_ovf_r;
      if (frame_evt)
      begin
        // status echoes register access and address; write data reads back zero
        status_out <= reg_mode ? ctl_s2_r : 8'h00;
        rdata_out <= (reg_mode && !ctl_s2_r[`AOC_C_WR]) ? rd_nxt : 16'h0000;
      end
    end
  end
endmodule // aoc_channel

// file: verilog/aoc_map.vh
// Notes on behaviour
// - writing 0x1235 to the code word register lifts write protection
// - any other code word value restores write protection
// - code word reads back 0x1235 when unlocked, zero when protected
// - maker parameters 16..30 accept writes only while unlocked
// - maker and user parameters are kept in nonvolatile storage
// - register 8 holds a fixed module type identifier
// - register 9 holds firmware version as ASCII characters
// - msb of minimum length register marks control byte optional
// - data type register reports channel layout, here word array 0x04
// - register 5 shows the scaled word sent to the converter
// - hardware gain is unsigned fraction times 2^-16, 0xffff is unity
// - maker factor unsigned times 2^-8, 0x0100 is one and default
// - feature bit 0 enables user line, bit 1 maker line, default one
// - feature bit 2 clear runs watchdog; overflow drives fallback value
// - feature bit 8 selects maker (0) or user (1) fallback value
// - user offset is signed 16-bit, default zero
// - user factor is signed times 2^-8, default 0x0100
// - user fallback output after reset and after 100ms without data; here bit 8 resets clear, so reset gives the zero maker fallback
// - control bit7 clear, bit6 set trims; bit4 gain, bit3 offset, bit1 up, bit0 down
// - trimming needs unlock; trimmed values committed when code word reset
// - control bit7 set is register access, bit6 write, bits 5..0 address
// - converter word is offset plus factor times input, maker before user
`ifndef AOC_MAP_VH
`define AOC_MAP_VH
`define AOC_A_RAW 6'h05
`define AOC_A_TYPE 6'h08
`define AOC_A_FW 6'h09
`define AOC_A_SRLEN 6'h0a
`define AOC_A_CHCNT 6'h0b
`define AOC_A_MINLEN 6'h0c
`define AOC_A_DTYPE 6'h0d
`define AOC_A_ALIGN 6'h0f
`define AOC_A_HWOFS 6'h11
`define AOC_A_HWGAIN 6'h12
`define AOC_A_MKOFS 6'h13
`define AOC_A_MKFAC 6'h14
`define AOC_A_CODE 6'h1f
`define AOC_A_FEAT 6'h20
`define AOC_A_USOFS 6'h21
`define AOC_A_USFAC 6'h22
`define AOC_A_USFB 6'h23
`define AOC_MAKER_LO 6'h10
`define AOC_MAKER_HI 6'h1e
`define AOC_UNLOCK 16'h1235
`define AOC_TYPE_ID 16'h0a5a
`define AOC_FW_VER 16'h3141
`define AOC_SRLEN_VAL 16'h0018
`define AOC_CHCNT_VAL 16'h0001
`define AOC_MINLEN_VAL 16'h8010
`define AOC_DTYPE_VAL 16'h0004
`define AOC_RST_FEAT 16'h0006
`define AOC_RST_FAC 16'h0100
`define AOC_RST_GAIN 16'hffff
`define AOC_RST_ZERO 16'h0000
`define AOC_F_USER 0
`define AOC_F_MAKER 1
`define AOC_F_WDOFF 2
`define AOC_F_FBSEL 8
`define AOC_C_REG 7
`define AOC_C_WR 6
`define AOC_C_GAIN 4
`define AOC_C_OFS 3
`define AOC_C_FAST 2
`define AOC_C_UP 1
`define AOC_C_DOWN 0
`define AOC_CLK_MHZ 50
`define AOC_WD_MS 100
`define AOC_SLOW_MS 1000
`define AOC_FAST_MS 50
`define AOC_MS_CYC (`AOC_CLK_MHZ * 1000)
`define AOC_WD_CYC (`AOC_WD_MS * `AOC_MS_CYC)
`define AOC_SLOW_CYC (`AOC_SLOW_MS * `AOC_MS_CYC)
`define AOC_FAST_CYC (`AOC_FAST_MS * `AOC_MS_CYC)
`endif

// file: verilog/aoc_line.v
`timescale 1ns/1ps
`include "aoc_map.vh"
// y = offset + factor * x / 256, saturated to signed 16 bits
module aoc_line (
  input wire [15:0] x_in,
  input wire [15:0] factor_in,
  input wire signed_factor_in,
  input wire [15:0] offset_in,
  output wire [15:0] y_out
);
  wire signed [16:0] fac_ext;
  wire signed [33:0] prod;
  wire signed [33:0] sum;
  assign fac_ext = signed_factor_in ? {factor_in[15], factor_in} : {1'b0, factor_in};
  assign prod = $signed(x_in) * fac_ext;
  // offset cast keeps the sum signed, so the shift stays arithmetic
  assign sum = (prod >>> 8) + $signed({{18{offset_in[15]}}, offset_in});
  // saturate rather than wrap
  assign y_out = (sum > 34'sd32767) ? 16'h7fff :
                 (sum < -34'sd32768) ? 16'h8000 : sum[15:0];
endmodule // aoc_line

// file: verification/aoc_channel_asserts.sv
`timescale 1ns/1ps
module aoc_channel_asserts #(
  parameter [31:0] WD_CYC = 64
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire frame_in,
  input wire [7:0] ctrl_in,
  input wire [15:0] data_in,
  input wire [7:0] status_out,
  input wire [15:0] rdata_out,
  input wire [15:0] dac_out,
  input wire run_out,
  input wire nv_commit_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  reg [31:0] idle_r;
  // register frames do not feed the watchdog, so only process frames restart the count
  always @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
      idle_r <= 32'h0;
    else if (frame_in && !ctrl_in[7])
      idle_r <= 32'h0;
    else if (idle_r < 32'hffff_0000)
      idle_r <= idle_r + 32'h1;
  sequence s_reg_take;
    $rose(frame_in) && ctrl_in[7];
  endsequence
  sequence s_proc_take;
    $rose(frame_in) && !ctrl_in[7];
  endsequence
  a_reg_echo: assert property (s_reg_take |-> ##6 status_out == ctrl_in)
    else $error("status does not echo control byte");
  a_proc_quiet: assert property (s_proc_take |-> ##6 status_out == 8'h00 && rdata_out == 16'h0000)
    else $error("process frame answer not zero");
  a_write_rdata: assert property ($rose(frame_in) && ctrl_in[7:6] == 2'b11 |-> ##6 rdata_out == 16'h0000)
    else $error("write frame returned data");
  a_code_read: assert property ($rose(frame_in) && ctrl_in == 8'h9f |-> ##6 rdata_out inside {16'h0000, 16'h1235})
    else $error("code word read gave illegal value");
  a_answer_hold: assert property (!frame_in |-> $stable(status_out) && $stable(rdata_out))
    else $error("answer changed between frames");
  a_wd_idle: assert property (idle_r > WD_CYC + 32'd8 |-> !run_out)
    else $error("run still high after watchdog span");
  a_commit_pulse: assert property (nv_commit_out |=> !nv_commit_out)
    else $error("commit pulse longer than one cycle");
  a_commit_cause: assert property (nv_commit_out |-> frame_in && ctrl_in == 8'hdf)
    else $error("commit without code word write");
endmodule // aoc_channel_asserts
bind aoc_channel aoc_channel_asserts #(.WD_CYC(WD_CYC)) chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .frame_in(frame_in), .ctrl_in(ctrl_in), .data_in(data_in), .status_out(status_out), .rdata_out(rdata_out),
  .dac_out(dac_out), .run_out(run_out), .nv_commit_out(nv_commit_out));

// file: verification/aoc_coupler_model.sv
`timescale 1ns/1ps
module aoc_coupler_model (
  input wire clk_in,
  output logic frame_out,
  output logic [7:0] ctrl_out,
  output logic [15:0] data_out,
  output logic sample_out
);
  initial
  begin
    frame_out = 1'b0;
    ctrl_out = 8'h00;
    data_out = 16'h0000;
    sample_out = 1'b0;
  end
  // byte and word held for the whole frame; released lines show the inverse
  task xfer(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    frame_out = 1'b1;
    ctrl_out = c;
    data_out = d;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    sample_out = 1'b1;
    @(negedge clk_in);
    sample_out = 1'b0;
    frame_out = 1'b0;
    ctrl_out = ~c;
    data_out = ~d;
    repeat (3) @(negedge clk_in);
  endtask
  // process-mode control byte held with no frame; idle byte around it restarts the step count
  task hold(input logic [7:0] c, input int n);
    @(negedge clk_in);
    ctrl_out = 8'h00;
    repeat (3) @(negedge clk_in);
    ctrl_out = c;
    repeat (n) @(negedge clk_in);
    ctrl_out = 8'h00;
    repeat (3) @(negedge clk_in);
  endtask
endmodule // aoc_coupler_model

// file: verification/tb_analog_out_channel_regs.sv
`timescale 1ns/1ps
`include "aoc_map.vh"
module tb_analog_out_channel_regs;
  localparam [31:0] WD = 64;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  wire frame_w, sample_w, run_w, commit_w;
  wire [7:0] ctrl_w, status_w;
  wire [15:0] data_w, rdata_w, dac_w;
  logic [23:0] expq [$];
  logic [21:0] tab [14];
  integer errors = 0;
  integer compares = 0;
  integer commits = 0;
  integer i;
  aoc_coupler_model cpl_u (.clk_in(clk_in), .frame_out(frame_w), .ctrl_out(ctrl_w), .data_out(data_w),
    .sample_out(sample_w));
  aoc_channel #(.WD_CYC(WD), .SLOW_CYC(32'd200), .FAST_CYC(32'd20)) dut_u (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .frame_in(frame_w), .ctrl_in(ctrl_w), .data_in(data_w), .status_out(status_w),
    .rdata_out(rdata_w), .dac_out(dac_w), .run_out(run_w), .nv_commit_out(commit_w));
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task rd(input logic [5:0] a, input logic [15:0] v);
    expq.push_back({2'b10, a, v});
    cpl_u.xfer({2'b10, a}, 16'h5a5a);
  endtask
  task wr(input logic [5:0] a, input logic [15:0] v);
    expq.push_back({2'b11, a, 16'h0000});
    cpl_u.xfer({2'b11, a}, v);
  endtask
  task proc(input logic [15:0] x);
    expq.push_back(24'h000000);
    cpl_u.xfer(8'h00, x);
  endtask
  always @(posedge clk_in)
    if (sample_w)
      check({8'h00, status_w, rdata_w}, {8'h00, expq.pop_front()});
  always @(posedge clk_in)
    if (commit_w)
      commits++;
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    give_verdict;
  end
  initial
  begin
    tab = '{{6'h08, `AOC_TYPE_ID}, {6'h09, `AOC_FW_VER}, {6'h0a, `AOC_SRLEN_VAL}, {6'h0b, `AOC_CHCNT_VAL},
      {6'h0c, 16'h8010}, {6'h0d, 16'h0004}, {6'h20, 16'h0006}, {6'h21, 16'h0000}, {6'h22, 16'h0100},
      {6'h23, 16'h0000}, {6'h14, 16'h0100}, {6'h12, 16'hffff}, {6'h1f, 16'h0000}, {6'h3f, 16'h0000}};
    i = $urandom(85);
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check({15'h0, run_w, dac_w}, 32'h0);
    for (i = 0; i < 14; i++)
      rd(tab[i][21:16], tab[i][15:0]);
    wr(6'h14, 16'h1234);
    rd(6'h14, `AOC_RST_FAC);
    wr(6'h08, 16'hffff);
    rd(6'h08, `AOC_TYPE_ID);
    wr(6'h1f, 16'h1235);
    rd(6'h1f, 16'h1235);
    wr(6'h20, 16'h0101);
    rd(6'h20, 16'h0101);
    wr(6'h21, 16'h7fff);
    wr(6'h22, 16'h7fff);
    wr(6'h23, 16'h0abc);
    // fast span 20 cycles: a 50-cycle hold gives two steps, 150 slow cycles give none
    cpl_u.hold(8'h4e, 50);
    rd(6'h11, 16'h0002);
    cpl_u.hold(8'h4a, 150);
    rd(6'h11, 16'h0002);
    cpl_u.hold(8'h4d, 50);
    rd(6'h11, 16'h0000);
    cpl_u.hold(8'h55, 50);
    rd(6'h12, 16'hfffd);
    cpl_u.hold(8'h56, 50);
    rd(6'h12, 16'hffff);
    proc(16'h4000 + 16'($urandom % 32'h4000));
    check({15'h0, run_w, dac_w}, {15'h0, 1'b1, 16'h7fff});
    wr(6'h21, 16'h8000);
    proc(16'hc000 + 16'($urandom % 32'h4000));
    check({16'h0, dac_w}, 32'h8000);
    wr(6'h21, 16'h0010);
    proc(16'h0000);
    check({16'h0, dac_w}, 32'h0010);
    rd(6'h05, 16'h0010);
    // fast watchdog span keeps the run short
    repeat (WD + 20) @(negedge clk_in);
    check({15'h0, run_w, dac_w}, {15'h0, 1'b0, 16'h0abc});
    wr(6'h1f, 16'h0000);
    check(commits, 32'd1);
    rd(6'h1f, 16'h0000);
    wr(6'h22, 16'h0200);
    rd(6'h22, 16'h7fff);
    cpl_u.hold(8'h4e, 50);
    rd(6'h11, 16'h0000);
    give_verdict;
  end
endmodule // tb_analog_out_channel_regs
